// file: design/bmc_bus_control.sv
`include "bmc_cfg.svh"

// ------------------------------------------------------------
// Cycle tracker: follows bus cycles, latches, decodes, counts
// ------------------------------------------------------------
module bmc_cycle_tracker #(
    parameter int WS_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic addr_strobe_n,
    input wire logic [31:2] proc_addr,
    input wire bmc_pkg::bmc_cyc_t proc_cyc,
    input wire logic ready_n,
    output logic latch_capture_input,
    output logic latch_oe_n,
    output logic [31:2] latched_addr,
    output bmc_pkg::bmc_cyc_t cyc_type,
    output logic [3:0] mem_cs_n,
    output logic [3:0] io_cs_n,
    output logic cyc_start,
    output logic wait_done_n,
    output logic next_addr_request_n,
    output logic half_width_bus_n
);
    import bmc_pkg::*;

    typedef struct packed {
        bmc_trk_state_t state;
        logic [WS_W-1:0] cnt;
        logic [WS_W-1:0] target;
        logic [31:2] addr;
        bmc_cyc_t cyc;
        logic [3:0] mem_cs_n;
        logic [3:0] io_cs_n;
        logic le;
        logic oe_n;
        logic start;
        logic wdone_n;
        logic na_n;
        logic half_n;
        logic pend;
        logic [31:2] p_addr;
        bmc_cyc_t p_cyc;
    } bmc_trk_t;

    bmc_trk_t s, next_s;

    generate
        if (WS_W < 4) begin : g_chk
            $error("WS_W too narrow for wait-state counts");
        end
    endgenerate

    // Parameter for half-width memory selects (none by default)
    localparam logic [3:0] HALF_MEM = 4'h0;

    // Reserved status is not a memory cycle, so it takes the default count
    function automatic logic is_mem(input bmc_cyc_t c);
        return c == CT_MEM_RD || c == CT_CODE_RD || c == CT_MEM_WR;
    endfunction

    function automatic logic [1:0] io_sel(input logic [31:2] a);
        return a[`BMC_IO_SEL_LSB+1 -: 2];
    endfunction

    // Wait count chosen by the decoded select
    function automatic logic [WS_W-1:0] ws_of(input logic [31:2] a,
                                              input bmc_cyc_t c);
        logic [WS_W-1:0] w;
        w = WS_W'(`BMC_INTA_WS);
        if (is_mem(c)) begin
            case (a[`BMC_TOP_BIT])
                1'b0: w = WS_W'(`BMC_MEM_WS0);
                default: w = WS_W'(`BMC_MEM_WS1);
            endcase
        end else if (c == CT_IO_RD || c == CT_IO_WR) begin
            case (io_sel(a))
                2'd0: w = WS_W'(`BMC_IO_WS0);
                2'd1: w = WS_W'(`BMC_IO_WS1);
                2'd2: w = WS_W'(`BMC_IO_WS2);
                default: w = WS_W'(`BMC_IO_WS3);
            endcase
        end
        return w;
    endfunction

    // Start a cycle: decode ahead of the latch, then latch together
    function automatic bmc_trk_t launch(input bmc_trk_t t,
                                        input logic [31:2] a,
                                        input bmc_cyc_t c);
        bmc_trk_t r;
        logic [1:0] mi;
        r = t;
        mi = {1'b0, a[`BMC_TOP_BIT]};
        r.state = TRK_WAIT;
        r.addr = a;
        r.cyc = c;
        r.le = 1'b1;
        r.start = 1'b1;
        r.cnt = WS_W'(`BMC_RST_CNT);
        r.target = ws_of(a, c);
        r.mem_cs_n = `BMC_RST_CS_N;
        r.io_cs_n = `BMC_RST_CS_N;
        if (is_mem(c)) begin
            r.mem_cs_n[mi] = 1'b0;
        end else if (c == CT_IO_RD || c == CT_IO_WR) begin
            r.io_cs_n[io_sel(a)] = 1'b0;
        end
        r.half_n = ~(is_mem(c) && HALF_MEM[mi]);
        return r;
    endfunction

    // Next state: pipelined addresses wait in a pending slot
    always_comb begin
        next_s = s;
        next_s.le = 1'b0;
        next_s.start = 1'b0;
        next_s.oe_n = 1'b0;
        next_s.na_n = 1'b1;
        case (s.state)
            TRK_IDLE: begin
                if (!addr_strobe_n) begin
                    next_s = launch(next_s, proc_addr, proc_cyc);
                end
            end
            TRK_WAIT: begin
                if (!addr_strobe_n && !s.pend) begin
                    next_s.pend = 1'b1;
                    next_s.p_addr = proc_addr;
                    next_s.p_cyc = proc_cyc;
                end
                if (s.cnt == s.target) begin
                    next_s.wdone_n = 1'b0;
                    next_s.state = TRK_DONE;
                end else begin
                    next_s.cnt = s.cnt + WS_W'(1);
                    // Ask for the next address only on full-width cycles
                    next_s.na_n = ~(s.half_n && !s.pend);
                end
            end
            TRK_DONE: begin
                if (!addr_strobe_n && !s.pend) begin
                    next_s.pend = 1'b1;
                    next_s.p_addr = proc_addr;
                    next_s.p_cyc = proc_cyc;
                end
                if (!ready_n) begin
                    next_s.wdone_n = 1'b1;
                    next_s.state = TRK_IDLE;
                    next_s.pend = 1'b0;
                    if (s.pend) begin
                        next_s = launch(next_s, s.p_addr, s.p_cyc);
                    end else if (!addr_strobe_n) begin
                        next_s = launch(next_s, proc_addr, proc_cyc);
                    end
                end
            end
            default: next_s.state = TRK_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.state <= TRK_IDLE;
            s.mem_cs_n <= `BMC_RST_CS_N;
            s.io_cs_n <= `BMC_RST_CS_N;
            s.wdone_n <= 1'b1;
            s.na_n <= 1'b1;
            s.half_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign latch_capture_input = s.le;
    assign latch_oe_n = s.oe_n;
    assign latched_addr = s.addr;
    assign cyc_type = s.cyc;
    assign mem_cs_n = s.mem_cs_n;
    assign io_cs_n = s.io_cs_n;
    assign cyc_start = s.start;
    assign wait_done_n = s.wdone_n;
    assign next_addr_request_n = s.na_n;
    assign half_width_bus_n = s.half_n;
endmodule

// ------------------------------------------------------------
// Signal generator: commands, transceiver control, ready
// ------------------------------------------------------------
module bmc_control_signal_gen (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cyc_start,
    input wire bmc_pkg::bmc_cyc_t cyc_type,
    input wire logic wait_done_n,
    output logic mem_read_cmd_n,
    output logic io_read_cmd_n,
    output logic io_write_cmd_n,
    output logic int_ack_n,
    output logic xcvr_enable_n,
    output logic xcvr_direction,
    output logic ready_n
);
    import bmc_pkg::*;

    typedef struct packed {
        logic mrd_n;
        logic io_read_cmd_n_n;
        logic io_write_cmd_n_n;
        logic inta_n;
        logic den_n;
        logic dir;
        logic rdy_n;
    } bmc_gen_t;

    bmc_gen_t g, next_g;

    // Commands open with the cycle and close when ready is given
    always_comb begin
        next_g = g;
        if (!g.rdy_n) begin
            next_g.rdy_n = 1'b1;
            next_g.mrd_n = 1'b1;
            next_g.io_read_cmd_n_n = 1'b1;
            next_g.io_write_cmd_n_n = 1'b1;
            next_g.inta_n = 1'b1;
            next_g.den_n = 1'b1;
        end else if (!wait_done_n) begin
            next_g.rdy_n = 1'b0;
        end
        if (cyc_start) begin
            next_g.dir = cyc_type[0];
            // Halt and reserved cycles move no data, transceivers stay off
            next_g.den_n = (cyc_type == CT_HALT || cyc_type == CT_RSVD);
            case (cyc_type)
                CT_MEM_RD, CT_CODE_RD: next_g.mrd_n = 1'b0;
                CT_IO_RD: next_g.io_read_cmd_n_n = 1'b0;
                CT_IO_WR: next_g.io_write_cmd_n_n = 1'b0;
                CT_INT_ACK: next_g.inta_n = 1'b0;
                default: next_g.mrd_n = 1'b1;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            g <= '1;
            g.dir <= 1'b0;
        end else begin
            g <= next_g;
        end
    end

    assign mem_read_cmd_n = g.mrd_n;
    assign io_read_cmd_n = g.io_read_cmd_n_n;
    assign io_write_cmd_n = g.io_write_cmd_n_n;
    assign int_ack_n = g.inta_n;
    assign xcvr_enable_n = g.den_n;
    assign xcvr_direction = g.dir;
    assign ready_n = g.rdy_n;
endmodule

// ------------------------------------------------------------
// Top: bus control between processor bus and slow devices
// ------------------------------------------------------------
// Behaviour
// - Pulse the address latch capture at every cycle start.
// - Address latch output enable stays active all the time.
// - Latched address holds for the cycle despite pipelined addresses.
// - Chip selects decoded early are latched with the address.
// - Two decoders: one-of-four I/O selects, memory selects 0 and 1 only.
// - The top address bit alone picks the memory device.
// - Decoded selects choose the wait-state count.
// - Transceiver direction high for writes, low for reads.
// - Direction is the latched write/read status.
// - Drive the active-low transceiver enable.
// - Data path covers 32 bits as four byte lanes.
// - Decode status outputs into the one matching command.
// - Memory data and code reads raise the memory read command.
// - I/O reads raise the I/O read command.
// - I/O writes raise the I/O write command.
// - Interrupt-acknowledge cycles raise the interrupt acknowledge.
// - Count wait states, flag done at the device's count.
// - Drive the processor's active-low ready to end cycles.
// - Split into cycle tracker and signal generator.
// - Drive the next-address request.
// - Never request next address on half-width cycles.
module bmc_bus_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic addr_strobe_n,
    input wire logic [31:2] proc_addr,
    input wire logic proc_mem_io,
    input wire logic proc_data_code,
    input wire logic proc_write_read,
    output logic latch_capture_input,
    output logic latch_oe_n,
    output logic [31:2] latched_addr,
    output logic [3:0] mem_cs_n,
    output logic [3:0] io_cs_n,
    output logic [3:0] lane_enable_n,
    output logic xcvr_direction,
    output logic xcvr_enable_n,
    output logic mem_read_cmd_n,
    output logic io_read_cmd_n,
    output logic io_write_cmd_n,
    output logic int_ack_n,
    output logic wait_done_n,
    output logic ready_n,
    output logic next_addr_request_n,
    output logic half_width_bus_n
);
    import bmc_pkg::*;

    bmc_cyc_t cyc_type;
    logic cyc_start;
    logic den_n;

    // Tracker and generator share only start, type, done and ready
    bmc_cycle_tracker #(.WS_W(4)) u_trk (
        .sys_clk(sys_clk),
        .rst(rst),
        .addr_strobe_n(addr_strobe_n),
        .proc_addr(proc_addr),
        .proc_cyc(bmc_cyc_t'({proc_mem_io, proc_data_code,
                               proc_write_read})),
        .ready_n(ready_n),
        .latch_capture_input(latch_capture_input),
        .latch_oe_n(latch_oe_n),
        .latched_addr(latched_addr),
        .cyc_type(cyc_type),
        .mem_cs_n(mem_cs_n),
        .io_cs_n(io_cs_n),
        .cyc_start(cyc_start),
        .wait_done_n(wait_done_n),
        .next_addr_request_n(next_addr_request_n),
        .half_width_bus_n(half_width_bus_n)
    );

    bmc_control_signal_gen u_gen (
        .sys_clk(sys_clk),
        .rst(rst),
        .cyc_start(cyc_start),
        .cyc_type(cyc_type),
        .wait_done_n(wait_done_n),
        .mem_read_cmd_n(mem_read_cmd_n),
        .io_read_cmd_n(io_read_cmd_n),
        .io_write_cmd_n(io_write_cmd_n),
        .int_ack_n(int_ack_n),
        .xcvr_enable_n(den_n),
        .xcvr_direction(xcvr_direction),
        .ready_n(ready_n)
    );

    // One enable per byte-wide transceiver, all four move together
    assign lane_enable_n = {4{den_n}};
    assign xcvr_enable_n = den_n;
endmodule

// file: design/bmc_cfg.svh
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH

// ------------------------------------------------------------
// Wait-state counts, in sys_clk cycles after the cycle start
// ------------------------------------------------------------
`define BMC_MEM_WS0 4'h4
`define BMC_MEM_WS1 4'h2
`define BMC_MEM_WS2 4'h1
`define BMC_MEM_WS3 4'h1
`define BMC_IO_WS0 4'h3
`define BMC_IO_WS1 4'h5
`define BMC_IO_WS2 4'h3
`define BMC_IO_WS3 4'h1
`define BMC_INTA_WS 4'h3

// ------------------------------------------------------------
// Decoder field positions
// ------------------------------------------------------------
`define BMC_IO_SEL_LSB 3
`define BMC_TOP_BIT 31

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BMC_RST_CS_N 4'hf
`define BMC_RST_CNT 4'h0

`endif

// file: design/bmc_pkg.sv
package bmc_pkg;
    // Encoding follows {mem_io, data_code, write_read} of the processor
    typedef enum logic [2:0] {
        CT_INT_ACK, CT_HALT, CT_IO_RD, CT_IO_WR,
        CT_CODE_RD, CT_RSVD, CT_MEM_RD, CT_MEM_WR
    } bmc_cyc_t;

    typedef enum logic [1:0] {
        TRK_IDLE, TRK_WAIT, TRK_DONE
    } bmc_trk_state_t;
endpackage

// file: dv/bmc_bus_monitor.sv
// ------------------------------------------------------------
// Port checker for the bus control top
// ------------------------------------------------------------
module bmc_bus_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic addr_strobe_n,
    input wire logic proc_mem_io,
    input wire logic proc_write_read,
    input wire logic latch_capture_input,
    input wire logic latch_oe_n,
    input wire logic [31:2] latched_addr,
    input wire logic [3:0] mem_cs_n,
    input wire logic [3:0] io_cs_n,
    input wire logic [3:0] lane_enable_n,
    input wire logic xcvr_direction,
    input wire logic xcvr_enable_n,
    input wire logic mem_read_cmd_n,
    input wire logic io_read_cmd_n,
    input wire logic io_write_cmd_n,
    input wire logic int_ack_n,
    input wire logic wait_done_n,
    input wire logic ready_n,
    input wire logic next_addr_request_n,
    input wire logic half_width_bus_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Latch strobe is a single pulse per cycle start
    pulse_one_a: assert property (
        latch_capture_input |=> !latch_capture_input)
        else $error("latch strobe longer than one cycle");
    oe_low_a: assert property (latch_oe_n == 1'b0)
        else $error("latch output enable went inactive");
    addr_hold_a: assert property (
        !latch_capture_input |-> $stable(latched_addr))
        else $error("latched address moved mid cycle");
    // Pending launches use stored status, so only direct starts compare
    dir_latch_a: assert property (
        latch_capture_input && $past(!addr_strobe_n) |=>
        xcvr_direction == $past(proc_write_read, 2))
        else $error("direction differs from latched status");
    cs_onehot_a: assert property ($onehot0({~mem_cs_n, ~io_cs_n}))
        else $error("more than one select active");
    cs_top_a: assert property (mem_cs_n[1:0] != 2'h3 |->
        mem_cs_n[1:0] == {~latched_addr[31], latched_addr[31]})
        else $error("memory select not chosen by top bit");
    lane_en_a: assert property (
        lane_enable_n == {4{xcvr_enable_n}})
        else $error("byte lanes differ from enable");
    cmd_one_a: assert property (
        $onehot0(~{mem_read_cmd_n, io_read_cmd_n, io_write_cmd_n, int_ack_n}))
        else $error("two commands active");
    mem_cmd_a: assert property (
        $fell(mem_read_cmd_n) && $past(!addr_strobe_n, 2) |->
        $past(proc_mem_io, 2) && !$past(proc_write_read, 2))
        else $error("memory read for wrong cycle type");
    done_ready_a: assert property ($fell(wait_done_n) |=> !ready_n)
        else $error("ready did not follow count done");
    // Ready ends the cycle and takes count done and enable with it
    ready_end_a: assert property (!ready_n |=>
        ready_n && wait_done_n && xcvr_enable_n)
        else $error("cycle not closed after ready");
    na_half_a: assert property (
        !(!next_addr_request_n && !half_width_bus_n))
        else $error("next address asked on half width");

    cover property (!ready_n && !io_write_cmd_n);
    cover property (!int_ack_n);
    cover property (!ready_n ##1 latch_capture_input);
    cover property (!next_addr_request_n);
endmodule

bind bmc_bus_control bmc_bus_monitor mon (.sys_clk(sys_clk), .rst(rst),
    .addr_strobe_n(addr_strobe_n),
    .proc_mem_io(proc_mem_io), .proc_write_read(proc_write_read),
    .latch_capture_input(latch_capture_input), .latch_oe_n(latch_oe_n),
    .latched_addr(latched_addr), .mem_cs_n(mem_cs_n), .io_cs_n(io_cs_n),
    .lane_enable_n(lane_enable_n), .xcvr_direction(xcvr_direction),
    .xcvr_enable_n(xcvr_enable_n), .mem_read_cmd_n(mem_read_cmd_n),
    .io_read_cmd_n(io_read_cmd_n), .io_write_cmd_n(io_write_cmd_n),
    .int_ack_n(int_ack_n), .wait_done_n(wait_done_n), .ready_n(ready_n),
    .next_addr_request_n(next_addr_request_n),
    .half_width_bus_n(half_width_bus_n));

// file: dv/bmc_proc_model.sv
// ------------------------------------------------------------
// Processor side: issues bus cycles and waits for ready
// ------------------------------------------------------------
module bmc_proc_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ready_n,
    output logic addr_strobe_n,
    output logic [31:2] proc_addr,
    output logic proc_mem_io,
    output logic proc_data_code,
    output logic proc_write_read
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        put('0, 3'h0, 1'b1);
    end

    task automatic put(input logic [31:2] a, input logic [2:0] c,
                       input logic s);
        addr_strobe_n = s;
        proc_addr = a;
        {proc_mem_io, proc_data_code, proc_write_read} = c;
    endtask

    // Called at a falling edge; n counts falling edges until ready.
    // Once released the lines show the inverse, as a pipelined next
    // address would, so a design that relatches them is caught.
    task automatic cycle(input logic [31:2] a, input logic [2:0] c,
                         input bit go, input bit pend, output int n);
        bit p;
        n = 0;
        if (go) put(a, c, 1'b0);
        forever begin
            @(negedge sys_clk);
            n++;
            if (ready_n === 1'b0 || rst || n >= 40) break;
            p = pend && (n == 2 || n == 3);
            put(p ? a : ~a, p ? c : ~c, !p);
        end
    endtask
endmodule

// file: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] c;
        logic [31:0] a;
        int w;
        logic [3:0] cmd, mcs, ics;
        logic en;
    } bmc_row_t;
    logic sys_clk, rst, addr_strobe_n, proc_mem_io, proc_data_code;
    logic proc_write_read, latch_capture_input, latch_oe_n;
    logic [31:2] proc_addr, latched_addr;
    logic [3:0] mem_cs_n, io_cs_n, lane_enable_n, cmd;
    logic xcvr_direction, xcvr_enable_n, mem_read_cmd_n, io_read_cmd_n;
    logic io_write_cmd_n, int_ack_n, wait_done_n, ready_n;
    logic next_addr_request_n, half_width_bus_n;
    int num_errors = 0, checks = 0, cyc_cnt = 0, n;
    // Cycle type, address, wait count, commands, selects, enable
    bmc_row_t rows [11] = '{
        '{3'h6, 32'h0000_1000, 4, 4'h7, 4'he, 4'hf, 1'b0},
        '{3'h6, 32'h8000_0040, 2, 4'h7, 4'hd, 4'hf, 1'b0},
        '{3'h4, 32'h8000_0100, 2, 4'h7, 4'hd, 4'hf, 1'b0},
        '{3'h7, 32'h0000_0020, 4, 4'hf, 4'he, 4'hf, 1'b0},
        '{3'h2, 32'h8000_0000, 3, 4'hb, 4'hf, 4'he, 1'b0},
        '{3'h3, 32'h0000_0008, 5, 4'hd, 4'hf, 4'hd, 1'b0},
        '{3'h2, 32'h0000_0010, 3, 4'hb, 4'hf, 4'hb, 1'b0},
        '{3'h3, 32'h8000_0018, 1, 4'hd, 4'hf, 4'h7, 1'b0},
        '{3'h0, 32'h0000_0004, 3, 4'he, 4'hf, 4'hf, 1'b0},
        '{3'h1, 32'h0000_0000, 3, 4'hf, 4'hf, 4'hf, 1'b1},
        '{3'h5, 32'h8000_0000, 3, 4'hf, 4'hf, 4'hf, 1'b1}
    };

    assign cmd = {mem_read_cmd_n, io_read_cmd_n, io_write_cmd_n, int_ack_n};

    bmc_bus_control dut (.sys_clk(sys_clk), .rst(rst),
        .addr_strobe_n(addr_strobe_n), .proc_addr(proc_addr),
        .proc_mem_io(proc_mem_io), .proc_data_code(proc_data_code),
        .proc_write_read(proc_write_read),
        .latch_capture_input(latch_capture_input), .latch_oe_n(latch_oe_n),
        .latched_addr(latched_addr), .mem_cs_n(mem_cs_n), .io_cs_n(io_cs_n),
        .lane_enable_n(lane_enable_n), .xcvr_direction(xcvr_direction),
        .xcvr_enable_n(xcvr_enable_n), .mem_read_cmd_n(mem_read_cmd_n),
        .io_read_cmd_n(io_read_cmd_n), .io_write_cmd_n(io_write_cmd_n),
        .int_ack_n(int_ack_n), .wait_done_n(wait_done_n), .ready_n(ready_n),
        .next_addr_request_n(next_addr_request_n),
        .half_width_bus_n(half_width_bus_n));

    bmc_proc_model cpu (.sys_clk(sys_clk), .rst(rst), .ready_n(ready_n),
        .addr_strobe_n(addr_strobe_n), .proc_addr(proc_addr),
        .proc_mem_io(proc_mem_io), .proc_data_code(proc_data_code),
        .proc_write_read(proc_write_read));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Values that must hold while reset is applied
    task automatic chk_rst;
        chk({latch_capture_input, latch_oe_n, xcvr_direction}, 32'h0);
        chk({mem_cs_n, io_cs_n, lane_enable_n}, 32'hfff);
        chk({cmd, wait_done_n, ready_n, xcvr_enable_n}, 32'h7f);
        chk({latched_addr, next_addr_request_n, half_width_bus_n},
            32'h3);
    endtask

    // Outputs are looked at while ready is low, before the cycle closes
    task automatic run(input bmc_row_t r);
        cpu.cycle(r.a[31:2], r.c, 1'b1, 1'b0, n);
        // Ready is seen at the falling edge W + 3 edges after the take
        chk(n, r.w + 3);
        chk(cmd, r.cmd);
        if (!r.en) chk({mem_cs_n, io_cs_n}, {r.mcs, r.ics});
        chk(latched_addr, r.a[31:2]);
        chk(xcvr_direction, r.c[0]);
        chk({xcvr_enable_n, wait_done_n}, {r.en, 1'b0});
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard, well above the length of the whole sequence
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 2000) begin
            num_errors++;
            close_out;
        end
    end

    initial begin
        rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk_rst;
        rst = 1'b0;
        // Back to back: each row starts at the edge that sees ready
        foreach (rows[i]) run(rows[i]);
        @(negedge sys_clk);
        chk({cmd, wait_done_n, xcvr_enable_n}, 32'h3f);
        // Two strobes mid cycle: one is kept pending, the other is lost
        cpu.cycle(30'h0000_0400, 3'h6, 1'b1, 1'b1, n);
        chk(n, 7);
        cpu.cycle(30'h0000_0400, 3'h6, 1'b0, 1'b0, n);
        chk(n, 7);
        chk(latched_addr, 30'h0000_0400);
        repeat (12) begin
            @(negedge sys_clk);
            chk(ready_n, 1'b1);
        end
        // Reset in the middle of a cycle, then a clean cycle again
        fork
            cpu.cycle(30'h0000_0400, 3'h6, 1'b1, 1'b0, n);
            begin
                repeat (3) @(negedge sys_clk);
                rst = 1'b1;
            end
        join
        @(negedge sys_clk);
        chk_rst;
        rst = 1'b0;
        run(rows[1]);
        close_out;
    end
endmodule
